// ==== sepr_access.sv ====
/*
 Sensor configuration EEPROM access controller: decodes commands and data
 frames from the output-pin interface, holds the eleven EEPROM registers
 and the diagnostic control word, runs erase, program and margin checks.
 Assumes an external front end that delivers decoded frames as pulses.
*/
// Function
// - Write 0x09 at 0x1B plus one data word sets diagnostic control.
// - Block read 0x03 at 0x10 returns first eight EEPROM words.
// - Words nine to eleven read singly with 0x01 at 0x18..0x1A.
// - Block write 0x0B at 0x10 loads eight words into consecutive registers.
// - Words nine to eleven written singly with 0x09 at 0x18..0x1A.
// - Margin check starts with command 0xE, level applied on output.
// - Margin loads 1 below threshold level and 0 above it.
// - Zero-cell margin select bit enables checking cells at zero.
// - Temporary overwrite: disables set, parity bits may be zero.
// - With only correction and reference disable set, new settings take effect.
// - Either lock bit locked refuses interface mode.
`timescale 1ns/1ns
module sepr_access
   import sepr_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Decoded frames from pin front end
   input wire logic i_cmd_valid,
   input wire logic [3:0] i_cmd_code,
   input wire logic [5:0] i_cmd_addr,
   input wire logic i_data_valid,
   input wire logic [15:0] i_data,
   input wire logic i_read_ack,
   // Pin level events
   input wire logic i_prog_pulse,
   input wire logic [7:0] i_margin_level,
   // Read data back to front end
   output logic o_rdata_valid,
   output logic [15:0] o_rdata,
   // Status
   output logic o_if_mode,
   output logic o_locked,
   output logic o_busy,
   // Active configuration to signal path
   output logic [SEPR_EEP_WORDS*16-1:0] o_active_cfg,
   output logic [15:0] o_diag
);
   typedef struct packed {
      sepr_state_e state;
      logic [SEPR_EEP_WORDS-1:0][15:0] regs;
      logic [15:0] diag;
      logic [3:0] cnt;
      logic [5:0] addr;
      logic [3:0] op;
      logic [15:0] pcnt;
      logic [7:0] mlvl;
      logic pulse_seen;
      logic rvalid;
      logic [15:0] rdata;
      logic if_mode;
      logic init_done;
      logic [SEPR_EEP_WORDS*16-1:0] active;
   } sepr_st_s;
   sepr_st_s st_r;
   sepr_st_s st_nxt;

   logic [SEPR_EEP_WORDS*16-1:0] cells;
   logic [SEPR_EEP_WORDS*16-1:0] marg_bits;
   logic nvm_erase;
   logic nvm_prog;
   logic nvm_marg;
   logic lock_any;

   // Lock check on stored cells
   assign lock_any = cells[SEPR_LOCKH_IDX*16 + SEPR_LOCKH_BIT]
                   | ~cells[SEPR_LOCKL_IDX*16 + SEPR_LOCKL_BIT];

   assign nvm_erase = (st_r.state == SEPR_NVM_OP) && (st_r.op == SEPR_CMD_ERASE);
   assign nvm_prog = (st_r.state == SEPR_NVM_OP) && (st_r.op == SEPR_CMD_PROGRAM);
   assign nvm_marg = (st_r.state == SEPR_NVM_OP) && (st_r.op == SEPR_CMD_MARGIN);

   sepr_cell_array u_cells (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_erase(nvm_erase),
      .i_program(nvm_prog),
      .i_margin(nvm_marg),
      .i_marg_zero(st_r.diag[SEPR_DIAG_MARG_ZERO]),
      .i_margin_level(st_r.mlvl),
      .i_mask(st_r.regs),
      .o_cells(cells),
      .o_margin_bits(marg_bits)
   );

   function automatic logic [15:0] rd_word(input sepr_st_s s, input logic [5:0] a);
      logic [15:0] w;
      w = 16'h0000;
      if (a == SEPR_ADR_DIAG)
         w = s.diag;
      else if (a >= SEPR_ADR_EEP_FIRST && a <= SEPR_ADR_EEP_LAST)
         w = s.regs[4'(a - SEPR_ADR_EEP_FIRST)];
      return w;
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      if (st_r.pulse_seen == 1'b0 && i_prog_pulse)
         st_nxt.pulse_seen = 1'b1;
      // Registers loaded from cells once after reset, then kept until overwritten
      if (!st_r.init_done)
      begin
         st_nxt.regs = cells;
         st_nxt.active = cells;
         st_nxt.init_done = 1'b1;
         st_nxt.if_mode = !lock_any;
      end
      case (st_r.state)
         SEPR_IDLE:
         begin
            if (i_cmd_valid && st_r.if_mode && !lock_any)
            begin
               st_nxt.addr = i_cmd_addr;
               st_nxt.cnt = 4'h0;
               st_nxt.op = i_cmd_code;
               case (i_cmd_code)
                  SEPR_CMD_READ:
                  begin
                     st_nxt.rdata = rd_word(st_r, i_cmd_addr);
                     st_nxt.rvalid = 1'b1;
                  end
                  SEPR_CMD_BLOCK_READ:
                  begin
                     st_nxt.rdata = rd_word(st_r, i_cmd_addr);
                     st_nxt.rvalid = 1'b1;
                     st_nxt.state = SEPR_BREAD;
                  end
                  SEPR_CMD_WRITE:
                     st_nxt.state = SEPR_WWRITE;
                  SEPR_CMD_BLOCK_WRITE:
                     st_nxt.state = SEPR_BWRITE;
                  SEPR_CMD_ERASE, SEPR_CMD_PROGRAM, SEPR_CMD_MARGIN:
                  begin
                     st_nxt.pulse_seen = 1'b0;
                     st_nxt.pcnt = 16'h0000;
                     st_nxt.state = SEPR_WAIT_PULSE;
                  end
                  default:
                     st_nxt.state = SEPR_IDLE;
               endcase
            end
         end
         SEPR_BREAD:
         begin
            if (i_read_ack)
            begin
               if (st_r.cnt == SEPR_BLOCK_LEN - 4'h1)
                  st_nxt.state = SEPR_IDLE;
               else
               begin
                  st_nxt.cnt = st_r.cnt + 4'h1;
                  st_nxt.addr = st_r.addr + 6'h01;
                  st_nxt.rdata = rd_word(st_r, st_r.addr + 6'h01);
                  st_nxt.rvalid = 1'b1;
               end
            end
         end
         SEPR_BWRITE, SEPR_WWRITE:
         begin
            if (i_data_valid)
            begin
               if (st_r.addr == SEPR_ADR_DIAG)
                  st_nxt.diag = i_data;
               else if (st_r.addr >= SEPR_ADR_EEP_FIRST && st_r.addr <= SEPR_ADR_EEP_LAST)
                  st_nxt.regs[4'(st_r.addr - SEPR_ADR_EEP_FIRST)] = i_data;
               st_nxt.addr = st_r.addr + 6'h01;
               st_nxt.cnt = st_r.cnt + 4'h1;
               if (st_r.state == SEPR_WWRITE || st_r.cnt == SEPR_BLOCK_LEN - 4'h1)
                  st_nxt.state = SEPR_IDLE;
            end
         end
         SEPR_WAIT_PULSE:
         begin
            if (st_r.pulse_seen || i_prog_pulse)
               st_nxt.pcnt = st_r.pcnt + 16'h0001;
            // Level held while the pulse stands, used after it falls
            if (i_prog_pulse)
               st_nxt.mlvl = i_margin_level;
            if (st_r.pcnt >= SEPR_PULSE_CYC_W - 16'h0001)
               st_nxt.state = SEPR_NVM_OP;
         end
         SEPR_NVM_OP:
         begin
            if (st_r.op == SEPR_CMD_MARGIN)
               st_nxt.regs = marg_bits;
            st_nxt.state = SEPR_IDLE;
         end
         default:
            st_nxt.state = SEPR_IDLE;
      endcase
      // Temporary overwrite takes effect once only these two disables remain
      if (st_r.diag == ((16'h0001 << SEPR_DIAG_ECC_OFF) | (16'h0001 << SEPR_DIAG_REF_OFF)))
         st_nxt.active = st_r.regs;
      // Refusing interface mode when locked
      if (st_r.init_done && lock_any)
         st_nxt.if_mode = 1'b0;
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_r <= '0;
         st_r.state <= SEPR_IDLE;
         st_r.diag <= SEPR_DIAG_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign o_rdata_valid = st_r.rvalid;
   assign o_rdata = st_r.rdata;
   assign o_if_mode = st_r.if_mode;
   assign o_locked = lock_any;
   assign o_busy = (st_r.state != SEPR_IDLE);
   assign o_active_cfg = st_r.active;
   assign o_diag = st_r.diag;
endmodule // sepr_access

// ==== sepr_access_sva.sv ====
/*
 Port checker for the EEPROM access controller.
 Assumes one clock and the async active-low reset of sepr_access.
*/
`timescale 1ns/1ns
module sepr_access_sva
   import sepr_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Frames
   input wire logic i_cmd_valid,
   input wire logic [3:0] i_cmd_code,
   input wire logic [5:0] i_cmd_addr,
   input wire logic i_data_valid,
   input wire logic [15:0] i_data,
   // Outputs
   input wire logic o_rdata_valid,
   input wire logic [15:0] o_rdata,
   input wire logic o_if_mode,
   input wire logic o_locked,
   input wire logic o_busy,
   input wire logic [SEPR_EEP_WORDS*16-1:0] o_active_cfg,
   input wire logic [15:0] o_diag
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);
   sequence s_take(code);
      i_cmd_valid && !o_busy && o_if_mode && !o_locked && i_cmd_code == code;
   endsequence
   sequence s_diag_load;
      s_take(SEPR_CMD_WRITE) ##0 (i_cmd_addr == SEPR_ADR_DIAG) ##[1:3] i_data_valid;
   endsequence
   a_read_answer: assert property (
      s_take(SEPR_CMD_READ) ##0 (i_cmd_addr inside {[6'h10:6'h1b]})
      |=> o_rdata_valid ##1 !o_rdata_valid) else $error("single read answer wrong");
   a_read_unmapped: assert property (
      s_take(SEPR_CMD_READ) ##0 (i_cmd_addr > SEPR_ADR_DIAG) |=> o_rdata_valid && o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_block_read: assert property (
      s_take(SEPR_CMD_BLOCK_READ) ##0 (i_cmd_addr == SEPR_ADR_EEP_FIRST) |=> o_busy)
      else $error("block read not started");
   a_block_write: assert property (
      s_take(SEPR_CMD_BLOCK_WRITE) ##0 (i_cmd_addr == SEPR_ADR_EEP_FIRST) |=> o_busy)
      else $error("block write not started");
   a_diag_write: assert property (
      s_diag_load |=> o_diag == $past(i_data)) else $error("diagnostic word not loaded");
   a_lock_refuse: assert property (
      o_locked && !o_busy && i_cmd_valid |=> !o_busy && !o_rdata_valid && $stable(o_diag))
      else $error("command taken while locked");
   a_lock_mode: assert property (
      o_locked [*3] |-> !o_if_mode) else $error("interface mode while locked");
   a_cfg_change: assert property (
      $past(i_rstn, 2) && !$stable(o_active_cfg) |-> $past(o_diag) == 16'h0005)
      else $error("config changed early");
endmodule // sepr_access_sva
bind sepr_access sepr_access_sva u_sva (.i_mclk(i_mclk), .i_rstn(i_rstn),
   .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_addr(i_cmd_addr),
   .i_data_valid(i_data_valid), .i_data(i_data), .o_rdata_valid(o_rdata_valid),
   .o_rdata(o_rdata), .o_if_mode(o_if_mode), .o_locked(o_locked), .o_busy(o_busy),
   .o_active_cfg(o_active_cfg), .o_diag(o_diag));

// ==== sepr_cell_array.sv ====
/*
 Nonvolatile cell array model: eleven words, one stored bit per cell, two fixed margin thresholds.
 Assumes erase/program strobes come from the access controller.
*/
`timescale 1ns/1ns
module sepr_cell_array
   import sepr_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Operation
   input wire logic i_erase,
   input wire logic i_program,
   input wire logic i_margin,
   input wire logic i_marg_zero,
   input wire logic [7:0] i_margin_level,
   input wire logic [SEPR_EEP_WORDS*16-1:0] i_mask,
   // Result
   output logic [SEPR_EEP_WORDS*16-1:0] o_cells,
   output logic [SEPR_EEP_WORDS*16-1:0] o_margin_bits
);
   typedef struct packed {
      logic [SEPR_EEP_WORDS*16-1:0] cells;
   } sepr_arr_s;
   sepr_arr_s st_r;
   sepr_arr_s st_nxt;
   logic [SEPR_EEP_WORDS*16-1:0] marg;

   // Threshold seen as high for a one cell, low for a zero cell
   genvar gi;
   generate
      for (gi = 0; gi < SEPR_EEP_WORDS*16; gi++)
      begin : g_bit
         assign marg[gi] = i_marg_zero ? (st_r.cells[gi] | (i_margin_level == 8'h00))
                                       : (st_r.cells[gi] & (i_margin_level < 8'hc0));
      end
   endgenerate

   always_comb
   begin
      st_nxt = st_r;
      if (i_erase)
         st_nxt.cells = st_r.cells & i_mask;
      else if (i_program)
         st_nxt.cells = st_r.cells | i_mask;
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
         st_r.cells <= SEPR_CELLS_RST;
      else
         st_r <= st_nxt;
   end

   assign o_cells = st_r.cells;
   assign o_margin_bits = i_margin ? marg : st_r.cells;
endmodule // sepr_cell_array

// ==== sepr_pkg.sv ====
/*
 Package for the sensor EEPROM access block: command codes, register
 addresses, diagnostic control word field positions and reset values.
 Assumes a decoded command/frame stream from the output-pin front end.
*/
package sepr_pkg;
   // Command codes
   localparam logic [3:0] SEPR_CMD_READ = 4'h1;
   localparam logic [3:0] SEPR_CMD_BLOCK_READ = 4'h3;
   localparam logic [3:0] SEPR_CMD_WRITE = 4'h9;
   localparam logic [3:0] SEPR_CMD_BLOCK_WRITE = 4'hb;
   localparam logic [3:0] SEPR_CMD_ERASE = 4'hc;
   localparam logic [3:0] SEPR_CMD_PROGRAM = 4'hd;
   localparam logic [3:0] SEPR_CMD_MARGIN = 4'he;
   // Register addresses
   localparam logic [5:0] SEPR_ADR_EEP_FIRST = 6'h10;
   localparam logic [5:0] SEPR_ADR_EEP_NINE = 6'h18;
   localparam logic [5:0] SEPR_ADR_EEP_TEN = 6'h19;
   localparam logic [5:0] SEPR_ADR_EEP_LAST = 6'h1a;
   localparam logic [5:0] SEPR_ADR_DIAG = 6'h1b;
   localparam int SEPR_EEP_WORDS = 11;
   localparam logic [3:0] SEPR_BLOCK_LEN = 4'h8;
   // Diagnostic control word fields
   localparam int SEPR_DIAG_ECC_OFF = 0;
   localparam int SEPR_DIAG_SP_OFF = 1;
   localparam int SEPR_DIAG_REF_OFF = 2;
   localparam int SEPR_DIAG_HALT = 3;
   localparam int SEPR_DIAG_PROTO_OFF = 4;
   localparam int SEPR_DIAG_MARG_ZERO = 5;
   localparam logic [15:0] SEPR_DIAG_RST = 16'h0000;
   // Lock bits within word 0x11 and 0x15
   localparam logic [3:0] SEPR_LOCKH_IDX = 4'h1;
   localparam int SEPR_LOCKH_BIT = 14;
   localparam logic [3:0] SEPR_LOCKL_IDX = 4'h5;
   localparam int SEPR_LOCKL_BIT = 14;
   // Cell content seen at power-up: unlocked, all else clear
   localparam logic [SEPR_EEP_WORDS*16-1:0] SEPR_CELLS_RST =
      176'h1 << (SEPR_LOCKL_IDX*16 + SEPR_LOCKL_BIT);
   // Pulse timing
   localparam int SEPR_CLK_MHZ = 25;
   localparam int SEPR_PULSE_MIN_US = 1;
   localparam int SEPR_PULSE_CYC = SEPR_PULSE_MIN_US * SEPR_CLK_MHZ;
   localparam logic [15:0] SEPR_PULSE_CYC_W = 16'(SEPR_PULSE_CYC);
   typedef enum logic [2:0] {
      SEPR_IDLE, SEPR_BREAD, SEPR_BWRITE, SEPR_WWRITE, SEPR_WAIT_PULSE, SEPR_NVM_OP
   } sepr_state_e;
endpackage

// ==== sepr_programmer.sv ====
/*
 Behavioural programmer: command and data frames, read acks, pin pulses.
 Assumes the controller samples all frame inputs on the rising clock edge.
*/
`timescale 1ns/1ns
module sepr_programmer
   import sepr_pkg::*;
(
   // Clock
   input wire logic i_mclk,
   // Frames
   output logic o_cmd_valid,
   output logic [3:0] o_cmd_code,
   output logic [5:0] o_cmd_addr,
   output logic o_data_valid,
   output logic [15:0] o_data,
   output logic o_read_ack,
   // Pin levels
   output logic o_prog_pulse,
   output logic [7:0] o_margin_level
);
   initial
   begin
      {o_cmd_valid, o_data_valid, o_read_ack, o_prog_pulse} = 4'h0;
      {o_cmd_code, o_cmd_addr, o_data, o_margin_level} = 34'h0;
   end
   // Idle buses show a changed pattern
   task automatic send_cmd(input logic [3:0] code, input logic [5:0] adr);
      @(posedge i_mclk);
      {o_cmd_valid, o_cmd_code, o_cmd_addr} <= {1'b1, code, adr};
      @(posedge i_mclk);
      {o_cmd_valid, o_cmd_code, o_cmd_addr} <= {1'b0, ~code, ~adr};
   endtask
   task automatic send_word(input logic [15:0] w);
      @(posedge i_mclk);
      {o_data_valid, o_data} <= {1'b1, w};
      @(posedge i_mclk);
      {o_data_valid, o_data} <= {1'b0, ~w};
   endtask
   task automatic ack_word();
      @(posedge i_mclk);
      o_read_ack <= 1'b1;
      @(posedge i_mclk);
      o_read_ack <= 1'b0;
   endtask
   task automatic nvm_pulse(input logic [7:0] lvl);
      @(posedge i_mclk);
      {o_prog_pulse, o_margin_level} <= {1'b1, lvl};
      repeat (SEPR_PULSE_CYC) @(posedge i_mclk);
      {o_prog_pulse, o_margin_level} <= {1'b0, ~lvl};
   endtask
endmodule // sepr_programmer

// ==== tb_sensor_eeprom_programming_sequence.sv ====
/*
 Self-checking bench for the EEPROM access controller.
 Assumes cells come up unlocked; each of the two passes erases a lock bit at its end.
*/
`timescale 1ns/1ns
module tb_sensor_eeprom_programming_sequence import sepr_pkg::*; ;
   logic i_mclk, i_rstn, cmd_valid, data_valid, read_ack, prog_pulse;
   logic [3:0] cmd_code;
   logic [5:0] cmd_addr;
   logic [15:0] data, o_rdata, o_diag;
   logic [7:0] margin_level;
   logic o_rdata_valid, o_if_mode, o_locked, o_busy;
   logic [SEPR_EEP_WORDS*16-1:0] o_active_cfg;
   logic [15:0] exp_q [$];
   logic [31:0] seed = 32'h0001414f;
   logic [10:0][15:0] cur, tgt, msk;
   int bad_count = 0;
   int n_compared = 0;
   sepr_programmer i_prog (.i_mclk(i_mclk), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
      .o_cmd_addr(cmd_addr), .o_data_valid(data_valid), .o_data(data), .o_read_ack(read_ack),
      .o_prog_pulse(prog_pulse), .o_margin_level(margin_level));
   sepr_access i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cmd_valid(cmd_valid),
      .i_cmd_code(cmd_code), .i_cmd_addr(cmd_addr), .i_data_valid(data_valid), .i_data(data),
      .i_read_ack(read_ack), .i_prog_pulse(prog_pulse), .i_margin_level(margin_level),
      .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .o_if_mode(o_if_mode),
      .o_locked(o_locked), .o_busy(o_busy), .o_active_cfg(o_active_cfg), .o_diag(o_diag));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic set_diag(input logic [15:0] w);
      i_prog.send_cmd(SEPR_CMD_WRITE, SEPR_ADR_DIAG);
      i_prog.send_word(w);
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      check(o_diag, w);
   endtask
   // Block write of eight words, then singles for the last three
   task automatic put_image(input logic [10:0][15:0] w);
      i_prog.send_cmd(SEPR_CMD_BLOCK_WRITE, SEPR_ADR_EEP_FIRST);
      for (int k = 0; k < 8; k++)
         i_prog.send_word(w[k]);
      for (int k = 8; k < 11; k++)
      begin
         i_prog.send_cmd(SEPR_CMD_WRITE, SEPR_ADR_EEP_FIRST + 6'(k));
         i_prog.send_word(w[k]);
      end
   endtask
   // Expected words noted first; the monitor compares them
   task automatic get_image(input logic [10:0][15:0] w);
      for (int k = 0; k < 11; k++)
         exp_q.push_back(w[k]);
      i_prog.send_cmd(SEPR_CMD_BLOCK_READ, SEPR_ADR_EEP_FIRST);
      repeat (8) i_prog.ack_word();
      for (int k = 8; k < 11; k++)
         i_prog.send_cmd(SEPR_CMD_READ, SEPR_ADR_EEP_FIRST + 6'(k));
      repeat (3) @(posedge i_mclk);
   endtask
   task automatic nvm_op(input logic [3:0] code, input logic [7:0] lvl);
      i_prog.send_cmd(code, SEPR_ADR_EEP_FIRST);
      i_prog.nvm_pulse(lvl);
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      check({15'h0000, o_busy}, 16'h0000);
   endtask
   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk)
      if (o_rdata_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check({15'h0000, o_rdata_valid}, 16'h0000);
         else
            check(o_rdata, exp_q.pop_front());
      end
   initial
   begin
      #(40 * 30000);
      bad_count++;
      close_out();
   end
   initial
   begin
      i_rstn = 1'b0;
      for (int r = 0; r < 2; r++)
      begin
         // Second pass starts with a power cycle
         i_rstn <= 1'b0;
         repeat (12) @(posedge i_mclk);
         i_rstn <= 1'b1;
         repeat (3) @(posedge i_mclk);
         @(negedge i_mclk);
         check({15'h0000, o_locked}, 16'h0000);
         check({15'h0000, o_if_mode}, 16'h0001);
         cur = SEPR_CELLS_RST;
         set_diag(16'h0007);
         get_image(cur);
         for (int k = 0; k < 11; k++)
            tgt[k] = 16'(rnd());
         tgt[SEPR_LOCKH_IDX][SEPR_LOCKH_BIT] = 1'b0;
         tgt[SEPR_LOCKL_IDX][SEPR_LOCKL_BIT] = 1'b1;
         for (int k = 0; k < 11; k++)
            msk[k] = ~((cur[k] ^ tgt[k]) & cur[k]);
         put_image(msk);
         get_image(msk);
         nvm_op(SEPR_CMD_ERASE, 8'h00);
         for (int k = 0; k < 11; k++)
            msk[k] = (cur[k] ^ tgt[k]) & tgt[k];
         put_image(msk);
         nvm_op(SEPR_CMD_PROGRAM, 8'h00);
         nvm_op(SEPR_CMD_MARGIN, 8'h10);
         get_image(tgt);
         set_diag(16'h0017);
         set_diag(16'h0005);
         for (int k = 0; k < 11; k++)
            check(o_active_cfg[k*16 +: 16], tgt[k]);
         set_diag(16'h0007);
         nvm_op(SEPR_CMD_MARGIN, 8'hc0);
         get_image('0);
         set_diag(16'h0027);
         nvm_op(SEPR_CMD_MARGIN, 8'h00);
         get_image('1);
         exp_q.push_back(16'h0000);
         i_prog.send_cmd(SEPR_CMD_READ, 6'h20);
         set_diag(16'h0008);
         repeat (8) @(posedge i_mclk);
         set_diag(16'h001a);
         // Clear the low-locking bit so the device locks itself
         msk = '1;
         msk[SEPR_LOCKL_IDX][SEPR_LOCKL_BIT] = 1'b0;
         put_image(msk);
         nvm_op(SEPR_CMD_ERASE, 8'h00);
         check({15'h0000, o_locked}, 16'h0001);
         check({15'h0000, o_if_mode}, 16'h0000);
         i_prog.send_cmd(SEPR_CMD_READ, SEPR_ADR_EEP_NINE);
         repeat (2) @(posedge i_mclk);
         @(negedge i_mclk);
         check({15'h0000, o_busy}, 16'h0000);
      end
      repeat (4) @(posedge i_mclk);
      check(16'(exp_q.size()), 16'h0000);
      close_out();
   end
endmodule // tb_sensor_eeprom_programming_sequence
